// file: shared/lcd_cursor_overlay_defines.vh
`ifndef LCD_CURSOR_OVERLAY_DEFINES_VH
`define LCD_CURSOR_OVERLAY_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_CURSOR_WIDTH 16'h8015
`define ADDR_CURSOR_HEIGHT_MODE 16'h8016
`define ADDR_CURSOR_DIRECTION 16'h8017
`define ADDR_LAYER_OVERLAY 16'h8018

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_CURSOR_WIDTH 8'h00
`define RESET_CURSOR_HEIGHT_MODE 8'h00
`define RESET_CURSOR_DIRECTION 8'h00
`define RESET_LAYER_OVERLAY 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CURSOR_SIZE_MSB 3
`define CURSOR_SHAPE_BIT 7
`define DIRECTION_MSB 1
`define THREE_LAYER_BIT 4
`define BLOCK3_GRAPHICS_BIT 3
`define BLOCK1_GRAPHICS_BIT 2
`define COMBINE_MSB 1

// ----------------------------------------
// Shift directions and composition methods
// ----------------------------------------
`define DIR_RIGHT 2'h0
`define DIR_LEFT 2'h1
`define DIR_UP 2'h2
`define DIR_DOWN 2'h3
`define COMBINE_OR 2'h0
`define COMBINE_XOR 2'h1
`define COMBINE_AND 2'h2

// ----------------------------------------
// Indirect command codes
// ----------------------------------------
`define CMD_DIR_BASE 8'h4C
`define CMD_DIR_MASK 8'hFC

`endif

// file: src/cursor_address_stepper.v
`timescale 1ns/10ps
`include "lcd_cursor_overlay_defines.vh"

module cursor_address_stepper #(
  parameter ADDR_WIDTH = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Control
  input wire addrLoad,
  input wire [ADDR_WIDTH-1:0] addrLoadValue,
  input wire memAccess,
  input wire [1:0] direction,
  input wire [ADDR_WIDTH-1:0] addressPitch,
  // Result
  output reg [ADDR_WIDTH-1:0] cursorAddr_reg
);

  reg [ADDR_WIDTH-1:0] cursorAddr_next;

  // ----------------------------------------
  // Step in raw address units only
  // ----------------------------------------
  // Nine-pixel characters are not compensated; software presets the step
  always @* begin
    cursorAddr_next = cursorAddr_reg;
    if (addrLoad) begin
      cursorAddr_next = addrLoadValue;
    end else if (memAccess) begin
      case (direction)
        `DIR_RIGHT: cursorAddr_next = cursorAddr_reg + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
        `DIR_LEFT: cursorAddr_next = cursorAddr_reg - {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
        `DIR_UP: cursorAddr_next = cursorAddr_reg - addressPitch;
        `DIR_DOWN: cursorAddr_next = cursorAddr_reg + addressPitch;
        default: cursorAddr_next = cursorAddr_reg;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      cursorAddr_reg <= {ADDR_WIDTH{1'b0}};
    end else begin
      cursorAddr_reg <= cursorAddr_next;
    end
  end

endmodule

// file: src/lcd_cursor_overlay_control.v
`timescale 1ns/10ps
`include "lcd_cursor_overlay_defines.vh"

// How it works
// - Block 3 line count is the smaller of block 1 and block 2 counts.
// - Block 4 count is lines per frame minus the block 3 count, minus one.
// - Dual panel blanks each block's difference from half of frame lines plus one.
// - Cursor width field holds pixel width minus one from character origin.
// - Shape bit clear gives underscore cursor, set gives block cursor.
// - Height field gives underscore row or block height, lines minus one.
// - Cursor address steps after each memory access without a load in the same cycle: one or address pitch.
// - Direction codes 00 right, 01 left, 10 up, 11 down; commands 4C-4F.
// - Cursor steps in address units even for nine-pixel characters.
// - Cursor form command takes width then height as its parameters.
// - Cursor direction command carries the direction in its code.
// - Overlay command takes the overlay register value as parameter.
// - Block 3 mode bit: clear text, set graphics.
// - Block 1 mode bit: clear text, set graphics.
// - Combine OR, XOR or AND of first two layers; third ORed only with three-layer and block 1 graphics set.
module lcd_cursor_overlay_control #(
  parameter ADDR_WIDTH = 16,
  parameter [7:0] CMD_CURSOR_FORM = 8'h5D,
  parameter [7:0] CMD_LAYER_OVERLAY = 8'h5B
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Direct register access
  input wire [15:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  output reg [7:0] regReadData,
  // Indirect command stream
  input wire cmdValid,
  input wire [7:0] cmdCode,
  input wire paramValid,
  input wire [7:0] paramData,
  // Frame geometry from other registers
  input wire dualPanel,
  input wire [7:0] linesPerFrame,
  input wire [7:0] block1LineCount,
  input wire [7:0] block2LineCount,
  input wire [ADDR_WIDTH-1:0] addressPitch,
  // Cursor address events
  input wire cursorAddrLoad,
  input wire [ADDR_WIDTH-1:0] cursorAddrLoadValue,
  input wire memAccess,
  // Layer pixels
  input wire layer1Pixel,
  input wire layer2Pixel,
  input wire layer3Pixel,
  // Cursor configuration
  output wire [3:0] cursorHorizSize,
  output wire [3:0] cursorVertSize,
  output wire cursorShapeSelect,
  output wire [1:0] cursorDirection,
  output wire [ADDR_WIDTH-1:0] cursorAddr,
  // Overlay configuration
  output wire threeLayerSelect,
  output wire block3GraphicsSelect,
  output wire block1GraphicsSelect,
  output wire [1:0] layerCombineMethod,
  output reg composedPixel,
  // Derived block geometry
  output reg [7:0] block3LineCount,
  output reg [7:0] block4LineCount,
  output reg [8:0] block1BlankLines,
  output reg [8:0] block2BlankLines
);

  // ----------------------------------------
  // Parameter sequencer states
  // ----------------------------------------
  localparam [1:0] SEQ_IDLE = 2'h0;
  localparam [1:0] SEQ_FORM_WIDTH = 2'h1;
  localparam [1:0] SEQ_FORM_HEIGHT = 2'h2;
  localparam [1:0] SEQ_OVERLAY = 2'h3;

  // ----------------------------------------
  // Reset values cut to field widths
  // ----------------------------------------
  localparam [7:0] WIDTH_RESET = `RESET_CURSOR_WIDTH;
  localparam [7:0] HEIGHT_MODE_RESET = `RESET_CURSOR_HEIGHT_MODE;
  localparam [7:0] DIRECTION_RESET = `RESET_CURSOR_DIRECTION;
  localparam [7:0] OVERLAY_RESET = `RESET_LAYER_OVERLAY;

  reg [3:0] cursorWidth_reg;
  reg [3:0] cursorWidth_next;
  reg [3:0] cursorHeight_reg;
  reg [3:0] cursorHeight_next;
  reg cursorShape_reg;
  reg cursorShape_next;
  reg [1:0] direction_reg;
  reg [1:0] direction_next;
  reg [4:0] overlay_reg;
  reg [4:0] overlay_next;
  reg [1:0] seqState_reg;
  reg [1:0] seqState_next;

  wire [8:0] halfFrame;
  wire [7:0] smallerBlock;
  wire layer3Enable;
  wire dirCommand;

  // Distance between a block's size and half frame, in lines
  function [8:0] lineDiff;
    input [7:0] sizeMinusOne;
    input [8:0] half;
    reg [8:0] size;
    begin
      size = {1'b0, sizeMinusOne} + 9'h001;
      if (size > half) begin
        lineDiff = size - half;
      end else begin
        lineDiff = half - size;
      end
    end
  endfunction

  // ----------------------------------------
  // Register writes, direct and indirect
  // ----------------------------------------
  // Direction codes carry their value, so they take no parameter bytes
  assign dirCommand = cmdValid && ((cmdCode & `CMD_DIR_MASK) == `CMD_DIR_BASE);

  // Direct writes win over a parameter in the same cycle; bytes are not lost
  // only if the host does not overlap both paths, which it never needs to.
  always @* begin
    cursorWidth_next = cursorWidth_reg;
    cursorHeight_next = cursorHeight_reg;
    cursorShape_next = cursorShape_reg;
    direction_next = direction_reg;
    overlay_next = overlay_reg;
    seqState_next = seqState_reg;
    // Any other command drops a half-finished parameter list
    if (cmdValid) begin
      if (cmdCode == CMD_CURSOR_FORM) begin
        seqState_next = SEQ_FORM_WIDTH;
      end else if (cmdCode == CMD_LAYER_OVERLAY) begin
        seqState_next = SEQ_OVERLAY;
      end else begin
        seqState_next = SEQ_IDLE;
      end
      if (dirCommand) begin
        direction_next = cmdCode[1:0];
      end
    end else if (paramValid) begin
      case (seqState_reg)
        SEQ_FORM_WIDTH: begin
          cursorWidth_next = paramData[`CURSOR_SIZE_MSB:0];
          seqState_next = SEQ_FORM_HEIGHT;
        end
        SEQ_FORM_HEIGHT: begin
          cursorHeight_next = paramData[`CURSOR_SIZE_MSB:0];
          cursorShape_next = paramData[`CURSOR_SHAPE_BIT];
          seqState_next = SEQ_IDLE;
        end
        SEQ_OVERLAY: begin
          overlay_next = paramData[`THREE_LAYER_BIT:0];
          seqState_next = SEQ_IDLE;
        end
        default: begin
          seqState_next = SEQ_IDLE;
        end
      endcase
    end
    if (regWrite) begin
      case (regAddr)
        `ADDR_CURSOR_WIDTH: begin
          cursorWidth_next = regWriteData[`CURSOR_SIZE_MSB:0];
        end
        `ADDR_CURSOR_HEIGHT_MODE: begin
          cursorHeight_next = regWriteData[`CURSOR_SIZE_MSB:0];
          cursorShape_next = regWriteData[`CURSOR_SHAPE_BIT];
        end
        `ADDR_CURSOR_DIRECTION: begin
          direction_next = regWriteData[`DIRECTION_MSB:0];
        end
        `ADDR_LAYER_OVERLAY: begin
          overlay_next = regWriteData[`THREE_LAYER_BIT:0];
        end
        default: begin
          overlay_next = overlay_next;
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      cursorWidth_reg <= WIDTH_RESET[`CURSOR_SIZE_MSB:0];
      cursorHeight_reg <= HEIGHT_MODE_RESET[`CURSOR_SIZE_MSB:0];
      cursorShape_reg <= HEIGHT_MODE_RESET[`CURSOR_SHAPE_BIT];
      direction_reg <= DIRECTION_RESET[`DIRECTION_MSB:0];
      overlay_reg <= OVERLAY_RESET[`THREE_LAYER_BIT:0];
      seqState_reg <= SEQ_IDLE;
    end else begin
      cursorWidth_reg <= cursorWidth_next;
      cursorHeight_reg <= cursorHeight_next;
      cursorShape_reg <= cursorShape_next;
      direction_reg <= direction_next;
      overlay_reg <= overlay_next;
      seqState_reg <= seqState_next;
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Unused bits read as zero
  // A read in the cycle of a write returns the old value
  always @(posedge ref_clk) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `ADDR_CURSOR_WIDTH: regReadData <= {4'h0, cursorWidth_reg};
        `ADDR_CURSOR_HEIGHT_MODE: regReadData <= {cursorShape_reg, 3'h0, cursorHeight_reg};
        `ADDR_CURSOR_DIRECTION: regReadData <= {6'h00, direction_reg};
        `ADDR_LAYER_OVERLAY: regReadData <= {3'h0, overlay_reg};
        default: regReadData <= 8'h00;
      endcase
    end
  end

  assign cursorHorizSize = cursorWidth_reg;
  assign cursorVertSize = cursorHeight_reg;
  assign cursorShapeSelect = cursorShape_reg;
  assign cursorDirection = direction_reg;
  assign threeLayerSelect = overlay_reg[`THREE_LAYER_BIT];
  assign block3GraphicsSelect = overlay_reg[`BLOCK3_GRAPHICS_BIT];
  assign block1GraphicsSelect = overlay_reg[`BLOCK1_GRAPHICS_BIT];
  assign layerCombineMethod = overlay_reg[`COMBINE_MSB:0];

  // ----------------------------------------
  // Cursor address
  // ----------------------------------------
  // Address wraps at the top of the address space
  cursor_address_stepper #(
    .ADDR_WIDTH(ADDR_WIDTH)
  ) i_cursor_address_stepper (
    .ref_clk(ref_clk),
    .reset(reset),
    .addrLoad(cursorAddrLoad),
    .addrLoadValue(cursorAddrLoadValue),
    .memAccess(memAccess),
    .direction(direction_reg),
    .addressPitch(addressPitch),
    .cursorAddr_reg(cursorAddr)
  );

  // ----------------------------------------
  // Layer composition
  // ----------------------------------------
  // Third layer is dropped when block 1 is text, since text leaves no room for it
  assign layer3Enable = threeLayerSelect && block1GraphicsSelect;

  always @(posedge ref_clk) begin
    if (reset) begin
      composedPixel <= 1'b0;
    end else begin
      case (layerCombineMethod)
        `COMBINE_OR: composedPixel <= layer1Pixel | layer2Pixel | (layer3Pixel & layer3Enable);
        `COMBINE_XOR: composedPixel <= (layer1Pixel ^ layer2Pixel) | (layer3Pixel & layer3Enable);
        `COMBINE_AND: composedPixel <= (layer1Pixel & layer2Pixel) | (layer3Pixel & layer3Enable);
        default: composedPixel <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Derived block geometry
  // ----------------------------------------
  assign halfFrame = ({1'b0, linesPerFrame} + 9'h001) >> 1;
  assign smallerBlock = (block1LineCount < block2LineCount) ? block1LineCount : block2LineCount;

  // Counts stay in lines-minus-one form, like the programmed block sizes
  // Block 4 wraps if both blocks overrun the frame; software avoids that
  always @(posedge ref_clk) begin
    if (reset) begin
      block3LineCount <= 8'h00;
      block4LineCount <= 8'h00;
      block1BlankLines <= 9'h000;
      block2BlankLines <= 9'h000;
    end else begin
      block3LineCount <= smallerBlock;
      block4LineCount <= linesPerFrame - smallerBlock - 8'h01;
      if (dualPanel) begin
        block1BlankLines <= lineDiff(block1LineCount, halfFrame);
        block2BlankLines <= lineDiff(block2LineCount, halfFrame);
      end else begin
        block1BlankLines <= 9'h000;
        block2BlankLines <= 9'h000;
      end
    end
  end

endmodule

// file: tb/lcd_cursor_overlay_properties.sv
`timescale 1ns/10ps
module lcd_cursor_overlay_properties #(
  parameter ADDR_WIDTH = 16
) (
  // Clock, reset and host side
  input wire ref_clk, reset, regWrite, cmdValid, memAccess, cursorAddrLoad,
  input wire [15:0] regAddr,
  input wire [7:0] regWriteData, cmdCode,
  // Geometry and pixels
  input wire dualPanel, layer1Pixel, layer2Pixel, layer3Pixel,
  input wire [7:0] linesPerFrame, block1LineCount, block2LineCount,
  input wire [ADDR_WIDTH-1:0] addressPitch, cursorAddr,
  // Observed outputs
  input wire [3:0] cursorHorizSize, cursorVertSize,
  input wire [1:0] cursorDirection, layerCombineMethod,
  input wire cursorShapeSelect, threeLayerSelect, block3GraphicsSelect,
  input wire block1GraphicsSelect, composedPixel,
  input wire [7:0] block3LineCount, block4LineCount,
  input wire [8:0] block1BlankLines, block2BlankLines
);
  // ----------------------------------------
  // Reference values
  // ----------------------------------------
  wire [7:0] minSl = (block1LineCount < block2LineCount) ? block1LineCount : block2LineCount;
  wire [7:0] b4 = linesPerFrame - minSl - 8'h01;
  wire [8:0] half = ({1'b0, linesPerFrame} + 9'h001) >> 1;
  wire [8:0] d1 = {1'b0, block1LineCount} + 9'h001;
  wire [8:0] blank1 = !dualPanel ? 9'h000 : (d1 > half) ? d1 - half : half - d1;
  wire [8:0] d2 = {1'b0, block2LineCount} + 9'h001;
  wire [8:0] blank2 = !dualPanel ? 9'h000 : (d2 > half) ? d2 - half : half - d2;
  wire [ADDR_WIDTH-1:0] addrNext = cursorDirection[1] ?
    (cursorDirection[0] ? cursorAddr + addressPitch : cursorAddr - addressPitch) :
    (cursorDirection[0] ? cursorAddr - 1'b1 : cursorAddr + 1'b1);
  wire pair = (layerCombineMethod == 2'h0) ? layer1Pixel | layer2Pixel :
    (layerCombineMethod == 2'h1) ? layer1Pixel ^ layer2Pixel : layer1Pixel & layer2Pixel;
  wire pixNow = (layerCombineMethod == 2'h3) ? 1'b0 :
    pair | (layer3Pixel & threeLayerSelect & block1GraphicsSelect);

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_block3_size: assert property (!reset |=> block3LineCount == $past(minSl))
    else $error("block 3 size wrong");
  a_block4_size: assert property (!reset |=> block4LineCount == $past(b4))
    else $error("block 4 size wrong");
  a_blank_lines: assert property (!reset |=> block1BlankLines == $past(blank1))
    else $error("blank lines wrong");
  a_block2_blank: assert property (!reset |=> block2BlankLines == $past(blank2))
    else $error("block 2 blank lines wrong");
  a_width_write: assert property (regWrite && regAddr == 16'h8015 |=>
    cursorHorizSize == $past(regWriteData[3:0])) else $error("width wrong");
  a_shape_height: assert property (regWrite && regAddr == 16'h8016 |=>
    {cursorShapeSelect, cursorVertSize} == $past({regWriteData[7], regWriteData[3:0]}))
    else $error("shape or height wrong");
  a_overlay_write: assert property (regWrite && regAddr == 16'h8018 |=>
    {threeLayerSelect, block3GraphicsSelect, block1GraphicsSelect, layerCombineMethod}
    == $past(regWriteData[4:0])) else $error("overlay wrong");
  a_dir_command: assert property (cmdValid && cmdCode[7:2] == 6'h13 &&
    !(regWrite && regAddr == 16'h8017) |=> cursorDirection == $past(cmdCode[1:0]))
    else $error("direction command wrong");
  a_addr_step: assert property (memAccess && !cursorAddrLoad |=>
    cursorAddr == $past(addrNext)) else $error("cursor step wrong");
  a_pixel_compose: assert property (!reset |=>
    composedPixel == $past(pixNow)) else $error("composition wrong");

  c_dual_blank: cover property (dualPanel && block1BlankLines != 9'h000);
  c_step_down: cover property (memAccess && cursorDirection == 2'h3);
  c_three_layer: cover property (threeLayerSelect && block1GraphicsSelect && layer3Pixel);
endmodule

bind lcd_cursor_overlay_control lcd_cursor_overlay_properties #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (.*);

// file: tb/host_cpu_model.sv
`timescale 1ns/10ps
module host_cpu_model (
  // Clock
  input wire ref_clk,
  // Register and command lines
  output reg [15:0] regAddr = 16'h0000,
  output reg regWrite = 1'b0,
  output reg regRead = 1'b0,
  output reg [7:0] regWriteData = 8'h00,
  output reg cmdValid = 1'b0,
  output reg [7:0] cmdCode = 8'h00,
  output reg paramValid = 1'b0,
  output reg [7:0] paramData = 8'h00
);
  task automatic wr(input [15:0] a, input [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    // Released data must not keep showing the last byte
    regWriteData <= ~d;
  endtask

  task automatic rd(input [15:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
  endtask

  task automatic ind(input isCmd, input [7:0] b);
    @(posedge ref_clk);
    cmdCode <= b;
    paramData <= b;
    cmdValid <= isCmd;
    paramValid <= !isCmd;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    paramValid <= 1'b0;
    cmdCode <= ~b;
    paramData <= ~b;
  endtask
endmodule

// file: tb/lcd_cursor_overlay_control_bench.sv
`timescale 1ns/10ps
module lcd_cursor_overlay_control_bench;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  wire [15:0] regAddr, cursorAddr;
  wire regWrite, regRead, cmdValid, paramValid;
  wire [7:0] regWriteData, cmdCode, paramData, regReadData, block3LineCount;
  reg dualPanel = 1'b0, memAccess = 1'b0, cursorAddrLoad = 1'b0;
  reg layer1Pixel = 1'b0, layer2Pixel = 1'b0, layer3Pixel = 1'b0;
  reg [7:0] linesPerFrame = 8'h00, block1LineCount = 8'h00, block2LineCount = 8'h00;
  reg [15:0] addressPitch = 16'h0028, cursorAddrLoadValue = 16'h0000, expAddr;
  reg [31:0] seed = 32'h000063CF;
  reg [7:0] msk [0:4] = '{8'h0F, 8'h8F, 8'h03, 8'h1F, 8'h00};
  reg [7:0] expQ [$];
  reg [7:0] v;
  reg readPend = 1'b0;
  integer num_errors = 0, cmp_count = 0, i, j;

  initial forever #2.5 ref_clk = ~ref_clk;

  host_cpu_model i_host_cpu_model (.*);
  lcd_cursor_overlay_control i_lcd_cursor_overlay_control (.*, .cursorHorizSize(),
    .cursorVertSize(), .cursorShapeSelect(), .cursorDirection(), .threeLayerSelect(),
    .block3GraphicsSelect(), .block1GraphicsSelect(), .layerCombineMethod(),
    .composedPixel(), .block4LineCount(), .block1BlankLines(), .block2BlankLines());

  function automatic [31:0] xs(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction

  task automatic check(input [15:0] seen, input [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("Errors %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic rdChk(input [15:0] a, input [7:0] e);
    expQ.push_back(e);
    i_host_cpu_model.rd(a);
  endtask

  // ----------------------------------------
  // Free-running geometry and pixels
  // ----------------------------------------
  always @(posedge ref_clk) begin
    seed = xs(seed);
    {dualPanel, layer1Pixel, layer2Pixel, layer3Pixel} <= seed[3:0];
    {linesPerFrame, block1LineCount, block2LineCount} <= seed[31:8];
  end

  // Read data stands from the edge after the strobe
  always @(posedge ref_clk) begin
    if (readPend)
      check({8'h00, regReadData}, {8'h00, expQ.pop_front()});
    readPend <= regRead;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    results;
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    for (i = 0; i < 5; i++)
      rdChk(16'h8015 + i[2:0], 8'h00);
    // Text mode still selected, so an underscore cursor is allowed
    i_host_cpu_model.ind(1'b1, 8'h5D);
    i_host_cpu_model.ind(1'b0, 8'h05);
    i_host_cpu_model.ind(1'b0, 8'h03);
    rdChk(16'h8015, 8'h05);
    rdChk(16'h8016, 8'h03);
    // An unknown command cancels the form, so the stray byte changes nothing
    i_host_cpu_model.ind(1'b1, 8'h5D);
    i_host_cpu_model.ind(1'b1, 8'h00);
    i_host_cpu_model.ind(1'b0, 8'h0E);
    rdChk(16'h8015, 8'h05);
    for (i = 0; i < 10; i++) begin
      j = i % 5;
      v = (j == 1) ? seed[7:0] | 8'h80 : seed[7:0];
      i_host_cpu_model.wr(16'h8015 + j[2:0], v);
      rdChk(16'h8015 + j[2:0], v & msk[j]);
    end
    v = seed[15:8];
    i_host_cpu_model.ind(1'b1, 8'h5B);
    i_host_cpu_model.ind(1'b0, v);
    rdChk(16'h8018, v & 8'h1F);
    for (i = 0; i < 4; i++) begin
      i_host_cpu_model.ind(1'b1, 8'h4C + i[1:0]);
      rdChk(16'h8017, {6'h00, i[1:0]});
      @(posedge ref_clk);
      expAddr = seed[15:0];
      cursorAddrLoadValue <= expAddr;
      cursorAddrLoad <= 1'b1;
      @(posedge ref_clk);
      cursorAddrLoad <= 1'b0;
      memAccess <= 1'b1;
      @(posedge ref_clk);
      memAccess <= 1'b0;
      expAddr = expAddr + (i == 0 ? 16'h0001 : i == 1 ? 16'hFFFF :
        i == 2 ? -addressPitch : addressPitch);
      @(negedge ref_clk);
      check(cursorAddr, expAddr);
    end
    repeat (3) @(posedge ref_clk);
    results;
  end
endmodule
